// >>> shared/ltc_pkg.sv
package ltc_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [15:0] LTC_SWITCH_ADDR = 16'h20e4;
  localparam logic [15:0] LTC_CONTROL_ADDR = 16'h20ec;
  localparam logic [31:0] LTC_SWITCH_RESET = 32'h0000_0000;
  localparam logic [31:0] LTC_CONTROL_RESET = 32'h0000_0003;
  // Switch register layout
  localparam int LTC_LOOP_SW_MSB = 13;
  localparam int LTC_SWITCH_ENABLE_A_BIT = 15;
  localparam int LTC_SPARE_SW_BIT = 14;
  // Control register layout
  localparam int LTC_RF_LSB = 13;
  localparam int LTC_RL_LSB = 10;
  localparam int LTC_GAIN_LSB = 5;
  localparam int LTC_LOW_MSB = 4;
  localparam logic [2:0] LTC_RF_DISCONNECT = 3'h0;
  localparam logic [15:0] LTC_USED_MASK = 16'hffff;
  // AHB encodings
  localparam logic [1:0] LTC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] LTC_HTRANS_SEQ = 2'h3;
  localparam logic LTC_HRESP_OKAY = 1'h0;
endpackage

// >>> src/ltc_field_reg.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Writable register field
// ****************************************
module ltc_field_reg #(
  parameter int W = 16,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  output logic [W-1:0] q
);
  // Sync reset to documented value, then load on write
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= RST;
    end else if (wr_en) begin
      q <= wr_data;
    end
  end
endmodule
`default_nettype wire

// >>> src/ltc_regs.sv
`timescale 1ns/1ns
`default_nettype none
module ltc_regs
  import ltc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [13:0] loop_switch,
  output logic switch_enable_a,
  output logic filter_path_connect,
  output logic [2:0] filter_resistor_select,
  output logic [2:0] load_resistor_select,
  output logic [4:0] gain_resistor_select,
  output logic [4:0] amp_aux_bits
);
  // ****************************************
  // Bus address phase capture
  // ****************************************
  logic wr_pend_r;
  logic [15:0] wr_addr_r;
  logic rd_req;
  logic wr_req;
  logic sw_wr;
  logic ctl_wr;
  logic [15:0] amp_switch_config;
  logic [15:0] amp_control;

  // Any size is taken as a whole word; hsize is not checked
  assign wr_req = hsel && hready && htrans[1] && hwrite;
  assign rd_req = hsel && hready && htrans[1] && !hwrite;

  // Remember write address for the data phase
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 16'h0000;
    end else begin
      wr_pend_r <= wr_req;
      wr_addr_r <= haddr[15:0];
    end
  end

  // Upper address bits must be zero for a hit
  logic wr_hi_ok_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_hi_ok_r <= 1'b0;
    end else begin
      wr_hi_ok_r <= (haddr[31:16] == 16'h0000);
    end
  end

  assign sw_wr = wr_pend_r && wr_hi_ok_r && (wr_addr_r == LTC_SWITCH_ADDR);
  assign ctl_wr = wr_pend_r && wr_hi_ok_r && (wr_addr_r == LTC_CONTROL_ADDR);

  // ****************************************
  // Storage
  // ****************************************
  // Reserved bit 14 is kept writable like its neighbours
  ltc_field_reg #(.W(16), .RST(LTC_SWITCH_RESET[15:0])) u_switch (
    .clk(clk),
    .reset(reset),
    .wr_en(sw_wr),
    .wr_data(hwdata[15:0]),
    .q(amp_switch_config)
  );

  ltc_field_reg #(.W(16), .RST(LTC_CONTROL_RESET[15:0])) u_control (
    .clk(clk),
    .reset(reset),
    .wr_en(ctl_wr),
    .wr_data(hwdata[15:0]),
    .q(amp_control)
  );

  // ****************************************
  // Read data and response
  // ****************************************
  // Address-phase hits; upper half of the address must be zero
  logic rd_hi_ok;
  logic rd_sw_hit;
  logic rd_ctl_hit;
  logic [31:0] rd_data_nxt;
  assign rd_hi_ok = (haddr[31:16] == 16'h0000);
  assign rd_sw_hit = rd_req && rd_hi_ok && (haddr[15:0] == LTC_SWITCH_ADDR);
  assign rd_ctl_hit = rd_req && rd_hi_ok && (haddr[15:0] == LTC_CONTROL_ADDR);

  // Read mux; idle cycles and unmapped words give zero, so the bus
  // never shows stale register contents
  always_comb begin
    rd_data_nxt = 32'h0000_0000;
    if (rd_sw_hit) begin
      rd_data_nxt = {16'h0000, amp_switch_config};
    end else if (rd_ctl_hit) begin
      rd_data_nxt = {16'h0000, amp_control};
    end
  end

  // Zero-wait slave: read data registered at end of address phase
  always_ff @(posedge clk) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else begin
      hrdata <= rd_data_nxt;
    end
  end

  // Always ready, always OKAY
  always_ff @(posedge clk) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp <= LTC_HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= LTC_HRESP_OKAY;
    end
  end

  // ****************************************
  // Analog select outputs
  // ****************************************
  // Registered again so outputs come from flops; one cycle behind storage
  always_ff @(posedge clk) begin
    if (reset) begin
      loop_switch <= 14'h0000;
      switch_enable_a <= 1'b0;
    end else begin
      loop_switch <= amp_switch_config[LTC_LOOP_SW_MSB:0];
      switch_enable_a <= amp_switch_config[LTC_SWITCH_ENABLE_A_BIT];
    end
  end

  // Filter ladder and its path switch
  always_ff @(posedge clk) begin
    if (reset) begin
      filter_resistor_select <= LTC_CONTROL_RESET[LTC_RF_LSB +: 3];
      filter_path_connect <= 1'b0;
    end else begin
      // Codes 1..7 pass straight to the ladder in order
      filter_resistor_select <= amp_control[LTC_RF_LSB +: 3];
      // Code 0 opens the path for a fast diagnostic route
      filter_path_connect <= amp_control[LTC_RF_LSB +: 3] != LTC_RF_DISCONNECT;
    end
  end

  // Load and gain resistor banks, plus the low control bits
  always_ff @(posedge clk) begin
    if (reset) begin
      load_resistor_select <= LTC_CONTROL_RESET[LTC_RL_LSB +: 3];
      gain_resistor_select <= LTC_CONTROL_RESET[LTC_GAIN_LSB +: 5];
      amp_aux_bits <= LTC_CONTROL_RESET[LTC_LOW_MSB:0];
    end else begin
      // Large load codes rely on software picking a big enough gain
      load_resistor_select <= amp_control[LTC_RL_LSB +: 3];
      gain_resistor_select <= amp_control[LTC_GAIN_LSB +: 5];
      amp_aux_bits <= amp_control[LTC_LOW_MSB:0];
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // Write lands in storage, then in the switch outputs one edge later
  a_switch_write_lands: assert property (@(posedge clk) disable iff (reset)
    sw_wr |=> amp_switch_config == $past(hwdata[15:0]) ##1
      loop_switch == $past(amp_switch_config[13:0]))
    else $error("switch write not reflected");

  // Each loop switch follows its own bit, so no two bits are swapped
  for (genvar n = 0; n <= LTC_LOOP_SW_MSB; n++) begin : g_loop_chk
    a_loop_bit_map: assert property (@(posedge clk) disable iff (reset)
      sw_wr |-> ##2 loop_switch[n] == $past(hwdata[n], 2))
      else $error("loop switch bit misrouted");
  end

  // Recalibration switch sits above the spare bit
  a_switch_enable_a_follows: assert property (@(posedge clk) disable iff (reset)
    sw_wr |-> ##2 switch_enable_a == $past(hwdata[15], 2))
    else $error("switch_enable_a switch wrong");

  // First edge out of reset: every switch open
  a_switch_reset_open: assert property (@(posedge clk)
    $fell(reset) |-> loop_switch == 14'h0000 && !switch_enable_a &&
      amp_switch_config == LTC_SWITCH_RESET[15:0])
    else $error("switches not open after reset");

  // Control register leaves reset with only the two low bits set
  a_control_reset_val: assert property (@(posedge clk)
    $fell(reset) |-> amp_control == 16'h0003 && amp_aux_bits == 5'h03)
    else $error("control reset value wrong");

  // Reset holds every select at its open or zero code
  a_reset_selects: assert property (@(posedge clk)
    reset |=> hrdata == 32'h0000_0000 && !filter_path_connect &&
      filter_resistor_select == 3'h0 && load_resistor_select == 3'h0 &&
      gain_resistor_select == 5'h00)
    else $error("selects not cleared by reset");

  // Path switch tracks the written filter code, not just its own copy
  a_filter_disconnect: assert property (@(posedge clk) disable iff (reset)
    ctl_wr |-> ##2 filter_path_connect == ($past(hwdata[15:13], 2) != LTC_RF_DISCONNECT))
    else $error("filter path not tied to code");

  // Field positions: each select shows its field two edges after the write
  a_filter_field_pos: assert property (@(posedge clk) disable iff (reset)
    ctl_wr |-> ##2 filter_resistor_select == $past(hwdata[15:13], 2))
    else $error("filter field misplaced");

  a_load_field_pos: assert property (@(posedge clk) disable iff (reset)
    ctl_wr |-> ##2 load_resistor_select == $past(hwdata[12:10], 2))
    else $error("load field misplaced");

  a_gain_field_pos: assert property (@(posedge clk) disable iff (reset)
    ctl_wr |-> ##2 gain_resistor_select == $past(hwdata[9:5], 2))
    else $error("gain field misplaced");

  a_aux_field_pos: assert property (@(posedge clk) disable iff (reset)
    ctl_wr |-> ##2 amp_aux_bits == $past(hwdata[4:0], 2))
    else $error("low control bits misplaced");

  // Read data carries the register as it stood at the address edge
  a_switch_read_back: assert property (@(posedge clk) disable iff (reset)
    rd_req && haddr == {16'h0000, LTC_SWITCH_ADDR} |=> hrdata == {16'h0000, $past(amp_switch_config)})
    else $error("switch read data wrong");

  a_control_read_back: assert property (@(posedge clk) disable iff (reset)
    rd_req && haddr == {16'h0000, LTC_CONTROL_ADDR} |=> hrdata == {16'h0000, $past(amp_control)})
    else $error("control read data wrong");

  // Idle cycles and unmapped words read as zero
  a_miss_read_zero: assert property (@(posedge clk) disable iff (reset)
    !(rd_req && haddr == {16'h0000, LTC_SWITCH_ADDR}) &&
      !(rd_req && haddr == {16'h0000, LTC_CONTROL_ADDR}) |=> hrdata == 32'h0000_0000)
    else $error("stray read data");

  // Reserved upper half never shows anything
  a_upper_read_zero: assert property (@(posedge clk) disable iff (reset)
    rd_req |=> hrdata[31:16] == 16'h0000)
    else $error("reserved upper bits not zero");

  // Write cycles leave the read bus at zero
  a_write_no_rdata: assert property (@(posedge clk) disable iff (reset)
    wr_req |=> hrdata == 32'h0000_0000)
    else $error("read data during write");

  // Storage changes only on a decoded write
  a_switch_holds: assert property (@(posedge clk) disable iff (reset)
    !sw_wr |=> $stable(amp_switch_config))
    else $error("switch register changed without write");

  a_control_holds: assert property (@(posedge clk) disable iff (reset)
    !ctl_wr |=> $stable(amp_control))
    else $error("control register changed without write");

  // A read never disturbs storage
  a_read_no_side: assert property (@(posedge clk) disable iff (reset)
    rd_req && !sw_wr && !ctl_wr |=> $stable(amp_switch_config) && $stable(amp_control))
    else $error("read changed a register");

  // Spare switch bit 14 is plain storage and drives nothing
  a_spare_bit_kept: assert property (@(posedge clk) disable iff (reset)
    sw_wr |=> amp_switch_config[LTC_SPARE_SW_BIT] == $past(hwdata[LTC_SPARE_SW_BIT]))
    else $error("spare switch bit not stored");

  // On every edge the load and gain selects are a one-edge-late copy of storage
  a_select_lag: assert property (@(posedge clk) disable iff (reset)
    load_resistor_select == $past(amp_control[12:10]) &&
      gain_resistor_select == $past(amp_control[9:5]))
    else $error("select outputs lag wrong");

  // A write with a nonzero upper address half must not land anywhere
  a_high_addr_miss: assert property (@(posedge clk) disable iff (reset)
    wr_req && haddr[31:16] != 16'h0000 |=> !sw_wr && !ctl_wr)
    else $error("aliased write accepted");

  // Zero-wait slave: always ready, always OKAY
  a_ready_okay: assert property (@(posedge clk) disable iff (reset)
    hreadyout && hresp == LTC_HRESP_OKAY)
    else $error("bus answer not ready or not okay");
endmodule
`default_nettype wire

// >>> dv/ltc_network_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Switch and resistor network model
// ****************************************
module ltc_network_model
  import ltc_pkg::*;
(
  input wire logic [13:0] loop_switch,
  input wire logic switch_enable_a,
  input wire logic filter_path_connect,
  input wire logic [2:0] filter_resistor_select,
  output logic net_ok,
  output logic [4:0] closed_count
);
  // Closed switch count, switch_enable_a switch included
  always_comb begin
    closed_count = 5'(switch_enable_a);
    for (int i = 0; i <= LTC_LOOP_SW_MSB; i++) begin
      closed_count = closed_count + 5'(loop_switch[i]);
    end
  end
  // Filter pin sees the output only for nonzero codes
  assign net_ok = (filter_path_connect === (filter_resistor_select != LTC_RF_DISCONNECT));
endmodule
`default_nettype wire

// >>> dv/testbench.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Register bank bench
// ****************************************
module testbench
  import ltc_pkg::*;
;
  logic clk = 0, reset = 1, hsel = 0, hwrite = 0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, switch_enable_a, filter_path_connect, net_ok;
  logic [13:0] loop_switch;
  logic [2:0] filter_resistor_select, load_resistor_select;
  logic [4:0] gain_resistor_select, amp_aux_bits, closed_count;
  int error_cnt = 0, check_count = 0;
  logic [31:0] d;
  always #20 clk = ~clk;
  ltc_regs i_ltc_regs (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .loop_switch(loop_switch),
    .switch_enable_a(switch_enable_a), .filter_path_connect(filter_path_connect),
    .filter_resistor_select(filter_resistor_select),
    .load_resistor_select(load_resistor_select),
    .gain_resistor_select(gain_resistor_select), .amp_aux_bits(amp_aux_bits));
  ltc_network_model i_ltc_network_model (.loop_switch(loop_switch),
    .switch_enable_a(switch_enable_a), .filter_path_connect(filter_path_connect),
    .filter_resistor_select(filter_resistor_select), .net_ok(net_ok),
    .closed_count(closed_count));
  // ****************************************
  // Bus and compare tasks
  // ****************************************
  // One single word transfer; hready is waited for, never assumed
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= LTC_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    if (hresp !== LTC_HRESP_OKAY) chk(32'h1, 32'h0);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Write, read back, then let the flopped outputs settle
  task automatic wr_rd(input logic [31:0] a, input logic [31:0] wd, input logic [31:0] exp);
    xfer(1'b1, a, wd);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
    @(posedge clk);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  // Whole run is under a hundred cycles; generous margin
  initial begin
    #200000;
    error_cnt++;
    results();
  end
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    // Reset values straight after release
    xfer(1'b0, 32'h20e4, 32'h0);
    chk(rd, LTC_SWITCH_RESET);
    xfer(1'b0, 32'h20ec, 32'h0);
    chk(rd, LTC_CONTROL_RESET);
    chk({switch_enable_a, loop_switch}, 32'h0);
    chk({filter_path_connect, amp_aux_bits}, 32'h3);
    // All switches closed; upper half stays zero, spare bit kept
    wr_rd(32'h20e4, 32'hffff_ffff, 32'h0000_ffff);
    chk({switch_enable_a, loop_switch}, 32'h7fff);
    chk(closed_count, 32'hf);
    wr_rd(32'h20e4, 32'h0000_2aaa, 32'h0000_2aaa);
    chk({switch_enable_a, loop_switch}, 32'h2aaa);
    // Every filter and load code, with gain and low bits alongside
    for (int i = 0; i < 8; i++) begin
      d = (i << 13) | ((7 - i) << 10) | ((i * 4 + 3) << 5) | (31 - i);
      wr_rd(32'h20ec, d | 32'hffff_0000, d);
      chk(filter_resistor_select, i);
      chk(filter_path_connect, (i != 0));
      chk(net_ok, 32'h1);
      chk(load_resistor_select, 7 - i);
      chk(gain_resistor_select, i * 4 + 3);
      chk(amp_aux_bits, 31 - i);
    end
    // Unmapped word between the two registers, and an alias with upper bits set
    wr_rd(32'h20e8, 32'hffff_ffff, 32'h0);
    wr_rd(32'h0001_20e4, 32'h0000_5555, 32'h0);
    xfer(1'b0, 32'h20e4, 32'h0);
    chk(rd, 32'h0000_2aaa);
    chk({switch_enable_a, loop_switch}, 32'h2aaa);
    // Field cleared back to zero, then the recommended filter code
    wr_rd(32'h20ec, 32'h0, 32'h0);
    chk({filter_path_connect, load_resistor_select}, 32'h0);
    wr_rd(32'h20ec, 32'h0000_e000, 32'h0000_e000);
    chk(filter_resistor_select, 32'h7);
    results();
  end
endmodule
`default_nettype wire
